// file: src/sdrlrp_top.v
`timescale 1ns/1ns
`include "sdrlrp_map.vh"
module sdrlrp_top #(
	parameter ECC_EN       = 1,
	parameter USER_REFRESH = 1,
	parameter AUTOPCH_EN   = 1,
	parameter INIT_CYC     = `SDRLRP_INIT_CYC,
	parameter REFI_CYC     = `SDRLRP_REFI_CYC
) (
	input  wire                        clk_sys,
	input  wire                        resetn,
	input  wire [`SDRLRP_ADDR_W-1:0]   local_addr,
	input  wire                        local_read_req,
	input  wire                        local_write_req,
	input  wire                        local_refresh_req,
	input  wire                        local_autopch_req,
	input  wire [`SDRLRP_LOC_DW-1:0]   local_wdata,
	input  wire [`SDRLRP_BE_W-1:0]     write_byte_enables,
	input  wire [3:0]                  rd_extra_lat,
	output reg                         local_init_done,
	output reg                         local_ready,
	output wire [`SDRLRP_LOC_DW-1:0]   local_rdata,
	output wire                        local_rdata_valid,
	output wire                        local_rdata_error,
	output reg                         local_refresh_ack,
	output reg                         local_wdata_req,
	output reg  [`SDRLRP_CMD_W-1:0]    mem_cmd_ff,
	output reg  [`SDRLRP_ADDR_W-1:0]   mem_addr_ff,
	output reg  [`SDRLRP_LOC_DW-1:0]   mem_wdata_ff,
	output reg  [`SDRLRP_BE_W-1:0]     mem_be_ff,
	input  wire                        mem_rd_valid,
	input  wire [`SDRLRP_LOC_DW-1:0]   mem_rdata,
	input  wire                        mem_rd_err
);

	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam [5:0] S_INIT = 6'h01;
	localparam [5:0] S_IDLE = 6'h02;
	localparam [5:0] S_PRE  = 6'h04;
	localparam [5:0] S_ACT  = 6'h08;
	localparam [5:0] S_ACC  = 6'h10;
	localparam [5:0] S_REF  = 6'h20;
	localparam       QW     = `SDRLRP_ADDR_W + 2;

	reg  [5:0]                state_ff;
	reg  [5:0]                nxt_state;
	reg  [31:0]               init_cnt_ff;
	reg  [31:0]               refi_cnt_ff;
	reg  [7:0]                trfc_cnt_ff;
	reg                       ref_due_ff;
	reg                       user_ref_ff;
	reg                       bank_open_ff;
	reg                       wdata_wait_ff;
	reg  [`SDRLRP_ADDR_W-1:0] cur_addr_ff;
	reg                       cur_wr_ff;
	reg                       cur_ap_ff;
	reg                       init_armed_ff;
	reg  [2:0]                q_count_ff;

	wire          q_in_valid;
	wire          q_in_ready;
	wire [QW-1:0] q_in_data;
	wire          q_out_valid;
	wire          q_out_ready;
	wire [QW-1:0] q_out_data;
	wire          ref_pending;
	wire          take;

	// ------------------------------------------------------------
	// request queue
	// ------------------------------------------------------------
	// one-hot request pair assumed; a write wins if both seen
	assign q_in_valid  = local_ready & (local_read_req | local_write_req);
	assign q_in_data   = {local_write_req, local_autopch_req & (AUTOPCH_EN != 0), local_addr};
	assign ref_pending = ref_due_ff | user_ref_ff;
	// queue drains only once init is done, and never ahead of a refresh
	assign take        = (state_ff == S_IDLE) & ~ref_pending & q_out_valid;
	assign q_out_ready = take;

	sdrlrp_fifo #(
		.WIDTH (QW),
		.DEPTH (`SDRLRP_FIFO_DEPTH),
		.AW    (`SDRLRP_FIFO_AW)
	) u_fifo (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.in_valid  (q_in_valid),
		.in_ready  (q_in_ready),
		.in_data   (q_in_data),
		.out_valid (q_out_valid),
		.out_ready (q_out_ready),
		.out_data  (q_out_data)
	);

	// ------------------------------------------------------------
	// command sequencer
	// ------------------------------------------------------------
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			S_INIT: begin
				if (init_armed_ff && init_cnt_ff == 32'h0000_0000)
					nxt_state = S_IDLE;
			end
			S_IDLE: begin
				if (ref_pending)
					nxt_state = S_REF;
				else if (q_out_valid)
					nxt_state = bank_open_ff ? S_PRE : S_ACT;
			end
			S_PRE:  nxt_state = S_ACT;
			S_ACT:  nxt_state = S_ACC;
			S_ACC: begin
				if (!cur_wr_ff || wdata_wait_ff)
					nxt_state = S_IDLE;
			end
			S_REF: begin
				if (trfc_cnt_ff == 8'h00)
					nxt_state = S_IDLE;
			end
			default: nxt_state = S_INIT;
		endcase
	end

	// ------------------------------------------------------------
	// ready, from a local copy of queue occupancy
	// ------------------------------------------------------------
	// ready is a flop, so it looks one entry ahead and drops as the last (fourth) slot is written
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			q_count_ff  <= 3'h0;
			local_ready <= 1'b0;
		end else begin
			if (q_in_valid & q_in_ready & ~take)
				q_count_ff <= q_count_ff + 3'h1;
			else if (take & ~(q_in_valid & q_in_ready))
				q_count_ff <= q_count_ff - 3'h1;
			local_ready <= q_in_ready & ~(q_in_valid & (q_count_ff == 3'h3));
		end
	end

	// ------------------------------------------------------------
	// init countdown and refresh bookkeeping
	// ------------------------------------------------------------
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			init_cnt_ff     <= 32'h0000_0000;
			init_armed_ff   <= 1'b0;
			local_init_done <= 1'b0;
			refi_cnt_ff     <= 32'h0000_0000;
			trfc_cnt_ff     <= 8'h00;
			ref_due_ff      <= 1'b0;
			user_ref_ff     <= 1'b0;
		end else begin
			// first edge loads the counter; done only once it has run down
			if (state_ff == S_INIT) begin
				init_armed_ff <= 1'b1;
				if (!init_armed_ff)
					init_cnt_ff <= INIT_CYC;
				else if (init_cnt_ff != 32'h0000_0000)
					init_cnt_ff <= init_cnt_ff - 32'h0000_0001;
			end
			if (state_ff == S_INIT && nxt_state == S_IDLE)
				local_init_done <= 1'b1;
			if (state_ff == S_IDLE && ref_pending) begin
				trfc_cnt_ff <= `SDRLRP_TRFC_CYC;
				ref_due_ff  <= 1'b0;
				user_ref_ff <= 1'b0;
			end else if (state_ff == S_REF && trfc_cnt_ff != 8'h00) begin
				trfc_cnt_ff <= trfc_cnt_ff - 8'h01;
			end
			// set beats clear: a request in the issue cycle is kept
			if (USER_REFRESH != 0 && local_refresh_req)
				user_ref_ff <= 1'b1;
			// timer runs only when the user does not own refresh
			if (USER_REFRESH == 0 && local_init_done) begin
				if (refi_cnt_ff >= REFI_CYC - 1) begin
					refi_cnt_ff <= 32'h0000_0000;
					ref_due_ff  <= 1'b1;
				end else begin
					refi_cnt_ff <= refi_cnt_ff + 32'h0000_0001;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// sequencer outputs
	// ------------------------------------------------------------
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_ff          <= S_INIT;
			local_refresh_ack <= 1'b0;
			local_wdata_req   <= 1'b0;
			bank_open_ff      <= 1'b0;
			wdata_wait_ff     <= 1'b0;
			cur_addr_ff       <= {`SDRLRP_ADDR_W{1'b0}};
			cur_wr_ff         <= 1'b0;
			cur_ap_ff         <= 1'b0;
			mem_cmd_ff        <= `SDRLRP_CMD_NOP;
			mem_addr_ff       <= {`SDRLRP_ADDR_W{1'b0}};
			mem_wdata_ff      <= {`SDRLRP_LOC_DW{1'b0}};
			mem_be_ff         <= {`SDRLRP_BE_W{1'b0}};
		end else begin
			state_ff          <= nxt_state;
			mem_cmd_ff        <= `SDRLRP_CMD_NOP;
			local_refresh_ack <= 1'b0;
			local_wdata_req   <= 1'b0;
			if (state_ff == S_IDLE && ref_pending) begin
				mem_cmd_ff        <= `SDRLRP_CMD_REF;
				local_refresh_ack <= 1'b1;
				bank_open_ff      <= 1'b0;
			end
			if (take) begin
				cur_wr_ff   <= q_out_data[QW-1];
				cur_ap_ff   <= q_out_data[QW-2];
				cur_addr_ff <= q_out_data[`SDRLRP_ADDR_W-1:0];
				if (bank_open_ff)
					mem_cmd_ff <= `SDRLRP_CMD_PRE;
			end
			if (state_ff == S_ACT) begin
				mem_cmd_ff   <= `SDRLRP_CMD_ACT;
				mem_addr_ff  <= cur_addr_ff;
				bank_open_ff <= 1'b1;
				if (cur_wr_ff)
					local_wdata_req <= 1'b1;
			end
			if (state_ff == S_ACC) begin
				wdata_wait_ff <= 1'b0;
				if (!cur_wr_ff || wdata_wait_ff) begin
					if (cur_wr_ff)
						mem_cmd_ff <= cur_ap_ff ? `SDRLRP_CMD_WRA : `SDRLRP_CMD_WR;
					else
						mem_cmd_ff <= cur_ap_ff ? `SDRLRP_CMD_RDA : `SDRLRP_CMD_RD;
					// with auto-precharge the bank is closed by the memory itself, otherwise it stays open
					bank_open_ff <= ~cur_ap_ff;
				end else begin
					// data sampled the edge after the request pulse
					mem_wdata_ff  <= local_wdata;
					mem_be_ff     <= write_byte_enables;
					wdata_wait_ff <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// read return path
	// ------------------------------------------------------------
	wire [`SDRLRP_LOC_DW:0] rd_word;
	wire                    rd_err_in;

	// error gated at the entry so the output comes straight off a flop
	assign rd_err_in = mem_rd_err & mem_rd_valid & (ECC_EN != 0);

	sdrlrp_rdpipe #(
		.WIDTH (`SDRLRP_LOC_DW + 1)
	) u_rdpipe (
		.clk_sys      (clk_sys),
		.resetn       (resetn),
		.extra_lat    (rd_extra_lat),
		.in_valid     (mem_rd_valid),
		.in_word      ({rd_err_in, mem_rdata}),
		.out_valid_ff (local_rdata_valid),
		.out_word_ff  (rd_word)
	);

	assign local_rdata = rd_word[`SDRLRP_LOC_DW-1:0];
	// error travels in the same word as its data
	assign local_rdata_error = rd_word[`SDRLRP_LOC_DW];

endmodule // sdrlrp_top

// file: src/sdrlrp_map.vh
`ifndef SDRLRP_MAP_VH
`define SDRLRP_MAP_VH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define SDRLRP_MEM_DW        8
`define SDRLRP_LOC_DW        32
`define SDRLRP_BE_W          4
`define SDRLRP_ADDR_W        24
`define SDRLRP_FIFO_DEPTH    4
`define SDRLRP_FIFO_AW       2

// ------------------------------------------------------------
// timing counts
// ------------------------------------------------------------
`define SDRLRP_CLK_PERIOD_NS 8
`define SDRLRP_INIT_US       200
`define SDRLRP_INIT_CYC      ((`SDRLRP_INIT_US * 1000) / `SDRLRP_CLK_PERIOD_NS)
`define SDRLRP_REFI_NS       7800
`define SDRLRP_REFI_CYC      (`SDRLRP_REFI_NS / `SDRLRP_CLK_PERIOD_NS)
`define SDRLRP_TRFC_CYC      8'h0F
`define SDRLRP_RD_LAT_BASE   4
`define SDRLRP_RD_LAT_MAX    8
`define SDRLRP_CMD_W         3

// ------------------------------------------------------------
// memory command codes
// ------------------------------------------------------------
`define SDRLRP_CMD_NOP       3'h0
`define SDRLRP_CMD_ACT       3'h1
`define SDRLRP_CMD_RD        3'h2
`define SDRLRP_CMD_WR        3'h3
`define SDRLRP_CMD_RDA       3'h4
`define SDRLRP_CMD_WRA       3'h5
`define SDRLRP_CMD_PRE       3'h6
`define SDRLRP_CMD_REF       3'h7

`endif

// file: src/sdrlrp_fifo.v
`timescale 1ns/1ns
module sdrlrp_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             clk_sys,
	input  wire             resetn,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_ff;
	reg [AW-1:0]    rd_ptr_ff;
	reg [AW:0]      count_ff;
	wire            push;
	wire            pop;
	integer         i;

	assign in_ready  = (count_ff != DEPTH[AW:0]);
	assign out_valid = (count_ff != {(AW+1){1'b0}});
	assign out_data  = mem_ff[rd_ptr_ff];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff  <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1)
				mem_ff[i] <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				mem_ff[wr_ptr_ff] <= in_data;
				wr_ptr_ff         <= wr_ptr_ff + 1'b1;
			end
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			if (push & ~pop)
				count_ff <= count_ff + 1'b1;
			else if (pop & ~push)
				count_ff <= count_ff - 1'b1;
		end
	end

endmodule // sdrlrp_fifo

// file: src/sdrlrp_rdpipe.v
`timescale 1ns/1ns
`include "sdrlrp_map.vh"
module sdrlrp_rdpipe #(
	parameter WIDTH = 34
) (
	input  wire             clk_sys,
	input  wire             resetn,
	input  wire [3:0]       extra_lat,
	input  wire             in_valid,
	input  wire [WIDTH-1:0] in_word,
	output reg              out_valid_ff,
	output reg  [WIDTH-1:0] out_word_ff
);

	// ------------------------------------------------------------
	// delay line, tap chosen by configured latency
	// ------------------------------------------------------------
	// valid and data share one word so they cannot drift apart
	reg [WIDTH:0] stage_ff [0:`SDRLRP_RD_LAT_MAX-1];
	wire [WIDTH:0] tap;

	genvar g;
	generate
		for (g = 0; g < `SDRLRP_RD_LAT_MAX; g = g + 1) begin : g_stage
			if (g == 0) begin : g_head
				always @(posedge clk_sys or negedge resetn) begin
					if (!resetn)
						stage_ff[g] <= {(WIDTH+1){1'b0}};
					else
						stage_ff[g] <= {in_valid, in_word};
				end
			end else begin : g_tail
				// split so stage 0 never names an index below the array
				always @(posedge clk_sys or negedge resetn) begin
					if (!resetn)
						stage_ff[g] <= {(WIDTH+1){1'b0}};
					else
						stage_ff[g] <= stage_ff[g-1];
				end
			end
		end
	endgenerate

	assign tap = (extra_lat >= 4'h7) ? stage_ff[7] : stage_ff[extra_lat[2:0]];

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			out_valid_ff <= 1'b0;
			out_word_ff  <= {WIDTH{1'b0}};
		end else begin
			out_valid_ff <= tap[WIDTH];
			out_word_ff  <= tap[WIDTH-1:0];
		end
	end

endmodule // sdrlrp_rdpipe

// file: tb/sdrlrp_sva.sv
`timescale 1ns/1ns
`include "sdrlrp_map.vh"
module sdrlrp_sva #(
	parameter INIT_CYC = 20
) (
	input wire                     clk_sys,
	input wire                     resetn,
	input wire [3:0]               rd_extra_lat,
	input wire                     mem_rd_valid,
	input wire                     mem_rd_err,
	input wire                     local_init_done,
	input wire                     local_ready,
	input wire                     local_read_req,
	input wire                     local_rdata_valid,
	input wire                     local_rdata_error,
	input wire                     local_refresh_ack,
	input wire                     local_wdata_req,
	input wire [`SDRLRP_CMD_W-1:0] mem_cmd_ff
);
	reg  [9:0] vp_ff;
	reg  [9:0] ep_ff;
	reg        ap_ff;
	integer    cnt_ff;
	// saturates like the design: settings above 7 act as 7
	wire [3:0] idx = (rd_extra_lat > 4'h7) ? 4'h8 : rd_extra_lat + 4'h1;

	// ----------------------------------------
	// delayed copies of the memory return
	// ----------------------------------------
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			vp_ff  <= 10'h000;
			ep_ff  <= 10'h000;
			ap_ff  <= 1'b0;
			cnt_ff <= 0;
		end else begin
			vp_ff <= {vp_ff[8:0], mem_rd_valid};
			ep_ff <= {ep_ff[8:0], mem_rd_valid & mem_rd_err};
			if (!local_init_done)
				cnt_ff <= cnt_ff + 1;
			if (mem_cmd_ff == `SDRLRP_CMD_RDA || mem_cmd_ff == `SDRLRP_CMD_WRA)
				ap_ff <= 1'b1;
			else if (mem_cmd_ff == `SDRLRP_CMD_ACT)
				ap_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_init_wait: assert property ($rose(local_init_done) |-> cnt_ff >= INIT_CYC)
		else $error("init done too early");
	a_hold_pre_init: assert property (!local_init_done |-> mem_cmd_ff == `SDRLRP_CMD_NOP)
		else $error("command before init done");
	a_rdv_align: assert property (local_rdata_valid == vp_ff[idx])
		else $error("read valid misaligned");
	a_err_align: assert property (local_rdata_error == ep_ff[idx])
		else $error("read error misaligned");
	a_err_qualified: assert property (local_rdata_error |-> local_rdata_valid)
		else $error("read error without valid");
	a_ack_pulse: assert property (local_refresh_ack |=> !local_refresh_ack)
		else $error("refresh ack longer than one cycle");
	a_ack_is_ref: assert property (local_refresh_ack == (mem_cmd_ff == `SDRLRP_CMD_REF))
		else $error("refresh ack not with refresh command");
	a_wdata_turn: assert property (local_wdata_req |=> !local_wdata_req ##1
		(mem_cmd_ff == `SDRLRP_CMD_WR || mem_cmd_ff == `SDRLRP_CMD_WRA))
		else $error("write command not after data request");
	a_no_pre_ap: assert property (ap_ff |-> mem_cmd_ff != `SDRLRP_CMD_PRE)
		else $error("precharge after auto-precharge access");

	c_refresh: cover property (local_refresh_ack);
	c_wra: cover property (mem_cmd_ff == `SDRLRP_CMD_WRA);
	c_rd_err: cover property (local_rdata_error);
	c_stall: cover property (!local_ready && local_read_req);
endmodule // sdrlrp_sva

bind sdrlrp_top sdrlrp_sva #(.INIT_CYC(INIT_CYC)) u_sva (.clk_sys, .resetn, .rd_extra_lat,
	.mem_rd_valid, .mem_rd_err, .local_init_done, .local_ready, .local_read_req,
	.local_rdata_valid, .local_rdata_error, .local_refresh_ack, .local_wdata_req, .mem_cmd_ff);

// file: tb/sdrlrp_user_model.sv
`timescale 1ns/1ns
module sdrlrp_user_model (
	input  wire        clk_sys,
	input  wire        resetn,
	input  wire        local_ready,
	input  wire        local_wdata_req,
	output reg         local_read_req,
	output reg         local_write_req,
	output reg  [23:0] local_addr,
	output reg         local_autopch_req,
	output reg  [31:0] local_wdata,
	output reg  [3:0]  write_byte_enables
);
	reg [35:0] wq[$];

	initial begin
		local_read_req = 1'b0;
		local_write_req = 1'b0;
		local_addr = 24'h000000;
		local_autopch_req = 1'b0;
		{write_byte_enables, local_wdata} = 36'h0;
	end

	// ----------------------------------------
	// request held until taken
	// ----------------------------------------
	// hold keeps the strobe up for a back-to-back call with gap 0
	task issue(input reg wr, input reg [23:0] a, input reg ap, input reg [35:0] d,
		input integer gap, input reg hold);
		begin
			repeat (gap) @(posedge clk_sys);
			if (wr)
				wq.push_back(d);
			local_write_req <= wr;
			local_read_req <= !wr;
			local_addr <= a;
			local_autopch_req <= ap;
			do @(posedge clk_sys); while (!local_ready);
			if (!hold) begin
				local_read_req <= 1'b0;
				local_write_req <= 1'b0;
				local_addr <= ~a;
			end
		end
	endtask

	// ----------------------------------------
	// write data on the falling edge of the request cycle
	// ----------------------------------------
	// driven in the request cycle so the next rising edge sees it
	always @(negedge clk_sys or negedge resetn) begin
		if (!resetn)
			wq.delete();
		else if (local_wdata_req && wq.size() > 0)
			{write_byte_enables, local_wdata} <= wq.pop_front();
		else
			{write_byte_enables, local_wdata} <= ~{write_byte_enables, local_wdata};
	end
endmodule // sdrlrp_user_model

// file: tb/tb_sdram_local_request_port.sv
`timescale 1ns/1ns
`include "sdrlrp_map.vh"
module tb_sdram_local_request_port;
	reg         clk_sys, resetn, local_refresh_req, mem_rd_valid, mem_rd_err;
	reg  [3:0]  rd_extra_lat;
	reg  [31:0] mem_rdata, rs, ms;
	wire        local_read_req, local_write_req, local_autopch_req, local_init_done;
	wire        local_ready, local_rdata_valid, local_rdata_error;
	wire        local_refresh_ack, local_wdata_req;
	wire [23:0] local_addr, mem_addr_ff;
	wire [31:0] local_wdata, local_rdata, mem_wdata_ff;
	wire [3:0]  write_byte_enables, mem_be_ff;
	wire [2:0]  mem_cmd_ff;
	integer     fail_count, checked, cyc, live, lat, acks, a0, first_ref, i, g;
	reg         hv[0:15], he[0:15];
	reg  [31:0] hd[0:15];
	reg  [2:0]  ecq[$];
	reg  [35:0] ewq[$];

	sdrlrp_top #(.INIT_CYC(20), .REFI_CYC(50)) uut (.clk_sys(clk_sys), .resetn(resetn),
		.local_addr(local_addr), .local_read_req(local_read_req),
		.local_write_req(local_write_req), .local_refresh_req(local_refresh_req),
		.local_autopch_req(local_autopch_req), .local_wdata(local_wdata),
		.write_byte_enables(write_byte_enables), .rd_extra_lat(rd_extra_lat),
		.local_init_done(local_init_done), .local_ready(local_ready),
		.local_rdata(local_rdata), .local_rdata_valid(local_rdata_valid),
		.local_rdata_error(local_rdata_error), .local_refresh_ack(local_refresh_ack),
		.local_wdata_req(local_wdata_req), .mem_cmd_ff(mem_cmd_ff), .mem_addr_ff(mem_addr_ff),
		.mem_wdata_ff(mem_wdata_ff), .mem_be_ff(mem_be_ff), .mem_rd_valid(mem_rd_valid),
		.mem_rdata(mem_rdata), .mem_rd_err(mem_rd_err));
	sdrlrp_user_model u_user (.clk_sys(clk_sys), .resetn(resetn), .local_ready(local_ready),
		.local_wdata_req(local_wdata_req), .local_read_req(local_read_req),
		.local_write_req(local_write_req), .local_addr(local_addr),
		.local_autopch_req(local_autopch_req), .local_wdata(local_wdata),
		.write_byte_enables(write_byte_enables));

	function [31:0] xs(input [31:0] s);
		reg [31:0] x;
		begin
			x = s ^ (s << 13);
			x = x ^ (x >> 17);
			xs = x ^ (x << 5);
		end
	endfunction

	task chk(input [35:0] got, input [35:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	task report_and_stop;
		begin
			if (fail_count == 0 && checked > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask

	// random request; expectations queued in acceptance order
	task send(input reg hold, input integer gap);
		begin
			rs = xs(rs);
			ecq.push_back(rs[0] ? (rs[1] ? 3'h5 : 3'h3) : (rs[1] ? 3'h4 : 3'h2));
			if (rs[0])
				ewq.push_back({rs[5:2], ~rs});
			u_user.issue(rs[0], rs[31:8], rs[1], {rs[5:2], ~rs}, gap, hold);
		end
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// monitor and memory-side stimulus
	// ----------------------------------------
	always @(negedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc > 20000) begin
			fail_count = fail_count + 1;
			report_and_stop;
		end
		live = resetn ? live + 1 : 0;
		g = (cyc - 2 - rd_extra_lat) & 15;
		if (live > 12) begin
			chk(local_rdata_valid, hv[g]);
			if (hv[g]) begin
				chk(local_rdata, hd[g]);
				chk(local_rdata_error, he[g]);
			end
		end
		if (mem_cmd_ff >= 3'h2 && mem_cmd_ff <= 3'h5) begin
			if (first_ref < 0)
				first_ref = acks;
			chk(mem_cmd_ff, ecq.pop_front());
			if (mem_cmd_ff[0])
				chk({mem_be_ff, mem_wdata_ff}, ewq.pop_front());
		end
		acks = acks + local_refresh_ack;
		ms = xs(ms);
		mem_rd_valid = ms[0];
		mem_rd_err = ms[1] & ms[2];
		mem_rdata = ms;
		hv[cyc & 15] = ms[0];
		he[cyc & 15] = ms[0] & ms[1] & ms[2];
		hd[cyc & 15] = ms;
	end

	// ----------------------------------------
	// main sequence, two latencies with reset between
	// ----------------------------------------
	initial begin
		{fail_count, checked, cyc, live, acks} = 0;
		{resetn, local_refresh_req, mem_rd_valid, mem_rd_err} = 4'h0;
		{rd_extra_lat, mem_rdata} = 36'h0;
		rs = 32'h4428;
		ms = 32'h4428;
		for (lat = 0; lat < 8; lat = lat + 6) begin
			@(negedge clk_sys);
			resetn = 1'b0;
			rd_extra_lat = lat;
			ecq.delete();
			ewq.delete();
			repeat (16) @(negedge clk_sys);
			resetn = 1'b1;
			first_ref = -1;
			fork
				for (i = 0; i < 5; i = i + 1)
					send(i < 4, i == 0);
				begin
					repeat (8) @(negedge clk_sys);
					chk(local_ready, 1'b0);
					chk(local_init_done, 1'b0);
					local_refresh_req = 1'b1;
					@(negedge clk_sys);
					local_refresh_req = 1'b0;
				end
			join
			for (i = 0; i < 24; i = i + 1)
				send((i % 3) == 1, (i % 3) == 2 ? 0 : 1 + i % 2);
			for (i = 0; i < 400 && ecq.size() > 0; i = i + 1)
				@(negedge clk_sys);
			chk(ecq.size(), 0);
			chk(ewq.size(), 0);
			chk(first_ref > 0, 1'b1);
			a0 = acks;
			local_refresh_req = 1'b1;
			@(negedge clk_sys);
			local_refresh_req = 1'b0;
			repeat (30) @(negedge clk_sys);
			chk(acks - a0, 1);
		end
		report_and_stop;
	end
endmodule // tb_sdram_local_request_port
